/* File: rtl/pulse_chop_consts.vh */
// constants for the pulse chop accumulator
`ifndef PULSE_CHOP_CONSTS_VH
`define PULSE_CHOP_CONSTS_VH
// register map
`define PATTERN_SLOT_A_ADDR 12'h10D
`define SLOT_ADDR_STRIDE 12'h020
`define PATTERN_RESET 16'h0000
// pattern register fields
`define INVERT_LSB 0
`define INVERT_MSB 3
`define NEGATE_LSB 4
`define NEGATE_MSB 7
// integration start time fields
`define START_COARSE_LSB 5
`define START_COARSE_MSB 12
`define START_FINE_LSB 0
`define START_FINE_MSB 4
// timing
`define CLK_PERIOD_PS 5000
`define COARSE_STEP_PS 1000000
`define FINE_STEP_PS 31250
`define COARSE_STEP_CYC ((`COARSE_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FINE_STEP_CYC ((`FINE_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// input connection modes
`define CONN_CONTINUOUS 2'h0
`define CONN_FLOAT 2'h1
`define CONN_PRECON 2'h2
// midscale bias
`define MIDSCALE_CODES 2048
`endif

/* File: rtl/slot_pattern_reg.v */
// one time slot's pulse pattern register
`timescale 1ns/100ps
`include "pulse_chop_consts.vh"
module slot_pattern_reg #(
    parameter [11:0] ADDR = 12'h10D
) (
    input wire ref_clk, // sample clock
    input wire rst, // async reset, active high
    input wire clk_en, // freezes state when low
    input wire wr_en, // register write strobe
    input wire [11:0] wr_addr, // register address
    input wire [15:0] wr_data, // write data
    output reg [15:0] value_q // stored pattern
);
    // ------------------------------------------------
    // storage, one copy per slot
    // ------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            value_q <= `PATTERN_RESET;
        end else if (clk_en && wr_en && wr_addr == ADDR) begin
            value_q <= wr_data;
        end
    end
endmodule // slot_pattern_reg

/* File: rtl/pulse_chop_accumulator.v */
// pulse sequencing, chop pattern and sample accumulation
`timescale 1ns/100ps
`include "pulse_chop_consts.vh"
module pulse_chop_accumulator #(
    parameter NUM_SLOTS = 12, // time slots
    parameter ADC_W = 14, // adc result width
    parameter ACC_W = 24, // accumulator width
    parameter INTEG_W = 4 // integration half-phase length in cycles
) (
    input wire ref_clk, // 200 MHz sample clock
    input wire rst, // async reset, active high
    input wire clk_en, // freezes all state when low
    input wire reg_wr, // pattern register write strobe
    input wire [11:0] reg_addr, // register address
    input wire [15:0] reg_wdata, // register write data
    input wire [3:0] slot_sel, // time slot for next sample
    input wire sample_start, // pulse: begin a sample
    input wire [12:0] integration_start_time, // coarse and fine offset
    input wire [7:0] pulse_repeat_count, // pulses per sample
    input wire [1:0] input_connect_mode, // input connection mode
    input wire midscale_bias_add, // add midscale to result
    input wire adc_valid, // pulse: adc result ready
    input wire [ADC_W-1:0] adc_data, // adc result, unsigned
    input wire pulse_window, // modulation pulse active
    input wire precon_done, // preconditioning finished
    output reg integ_active_q, // integrator running
    output reg integ_phase_q, // 1 = positive half
    output reg sensor_connect_q, // amplifier tied to sensor_input_pin
    output reg sensor_precon_q, // input tied to precondition level
    output reg [ACC_W-1:0] sample_data_q, // final accumulated value
    output reg sample_valid_q, // pulse: sample_data_q is new
    output reg busy_q, // sample in progress
    output reg [15:0] pattern_rd_q // selected slot pattern
);
    // ------------------------------------------------
    // per-slot pattern registers
    // ------------------------------------------------
    wire [16*NUM_SLOTS-1:0] pattern_flat;
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g = g + 1) begin : slots
            localparam [31:0] SLOT_ADDR = `PATTERN_SLOT_A_ADDR + g * `SLOT_ADDR_STRIDE;
            slot_pattern_reg #(
                .ADDR(SLOT_ADDR[11:0])
            ) u_pat (
                .ref_clk(ref_clk),
                .rst(rst),
                .clk_en(clk_en),
                .wr_en(reg_wr),
                .wr_addr(reg_addr),
                .wr_data(reg_wdata),
                .value_q(pattern_flat[16*g +: 16])
            );
        end
    endgenerate

    // ------------------------------------------------
    // input synchronisers for analog-side strobes
    // ------------------------------------------------
    reg [1:0] win_s_q;
    reg [1:0] pre_s_q;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            win_s_q <= 2'h0;
            pre_s_q <= 2'h0;
        end else if (clk_en) begin
            win_s_q <= {win_s_q[0], pulse_window};
            pre_s_q <= {pre_s_q[0], precon_done};
        end
    end
    wire win_sync = win_s_q[1];
    wire pre_sync = pre_s_q[1];

    // ------------------------------------------------
    // start time in cycles
    // ------------------------------------------------
    localparam [31:0] COARSE_CYC = `COARSE_STEP_CYC;
    localparam [31:0] FINE_CYC = `FINE_STEP_CYC;
    wire [7:0] coarse = integration_start_time[`START_COARSE_MSB:`START_COARSE_LSB];
    wire [4:0] fine = integration_start_time[`START_FINE_MSB:`START_FINE_LSB];
    wire [31:0] start_cyc = coarse * COARSE_CYC + fine * FINE_CYC;

    // ------------------------------------------------
    // sequencer state
    // ------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_WAIT = 3'h1;
    localparam [2:0] ST_HALF1 = 3'h2;
    localparam [2:0] ST_HALF2 = 3'h3;
    localparam [2:0] ST_CONV = 3'h4;
    localparam [2:0] ST_DONE = 3'h5;

    // ------------------------------------------------
    // working registers of the sequencer
    // ------------------------------------------------
    reg [2:0] state_q;
    reg [31:0] cnt_q;
    reg [7:0] pulse_idx_q; // pulses combined so far
    reg [1:0] pos_q;
    reg [3:0] slot_q;
    reg [7:0] total_q;
    reg bias_q;
    reg signed [ACC_W-1:0] acc_q;
    reg [15:0] cur_pat;
    integer i;
    integer j;

    // ------------------------------------------------
    // pattern of the active slot
    // ------------------------------------------------
    always @* begin
        cur_pat = 16'h0000;
        for (i = 0; i < NUM_SLOTS; i = i + 1) begin
            if (slot_q == i[3:0]) begin
                cur_pat = pattern_flat[16*i +: 16];
            end
        end
    end

    wire [3:0] invert_pat = cur_pat[`INVERT_MSB:`INVERT_LSB];
    wire [3:0] negate_pat = cur_pat[`NEGATE_MSB:`NEGATE_LSB];
    wire inv_now = invert_pat[pos_q];
    wire neg_now = negate_pat[pos_q];

    // ------------------------------------------------
    // signed pulse contribution
    // ------------------------------------------------
    wire signed [ACC_W-1:0] adc_ext = $signed({{(ACC_W-ADC_W){1'b0}}, adc_data});
    reg signed [ACC_W-1:0] acc_d;
    always @* begin
        acc_d = acc_q + adc_ext;
        if (neg_now) begin
            acc_d = acc_q - adc_ext;
        end
    end

    // ------------------------------------------------
    // final value, optional midscale bias
    // ------------------------------------------------
    localparam [31:0] MIDSCALE_FULL = `MIDSCALE_CODES;
    localparam [ACC_W-1:0] MIDSCALE = MIDSCALE_FULL[ACC_W-1:0];
    reg [ACC_W-1:0] result_d;
    always @* begin
        result_d = acc_q;
        if (bias_q) begin
            result_d = acc_q + MIDSCALE;
        end
    end

    // ------------------------------------------------
    // pulse sequencing and accumulation
    // ------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
            pulse_idx_q <= 8'h00;
            pos_q <= 2'h0;
            slot_q <= 4'h0;
            total_q <= 8'h00;
            bias_q <= 1'b0;
            acc_q <= {ACC_W{1'b0}};
            integ_active_q <= 1'b0;
            integ_phase_q <= 1'b0;
            sample_data_q <= {ACC_W{1'b0}};
            sample_valid_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            sample_valid_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // latch the set-up of the new sample
                    if (sample_start && pulse_repeat_count != 8'h00) begin
                        slot_q <= slot_sel;
                        total_q <= pulse_repeat_count;
                        pulse_idx_q <= 8'h00;
                        bias_q <= midscale_bias_add;
                        pos_q <= 2'h0;
                        acc_q <= {ACC_W{1'b0}};
                        cnt_q <= start_cyc;
                        busy_q <= 1'b1;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // hold off integration until start time from pulse window
                    if (!win_sync) begin
                        cnt_q <= start_cyc;
                    end else if (cnt_q == 32'h0) begin
                        integ_active_q <= 1'b1;
                        integ_phase_q <= ~inv_now;
                        cnt_q <= INTEG_W - 1;
                        state_q <= ST_HALF1;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_HALF1: begin
                    // swap integrator polarity at the mid point
                    if (cnt_q == 32'h0) begin
                        integ_phase_q <= ~integ_phase_q;
                        cnt_q <= INTEG_W - 1;
                        state_q <= ST_HALF2;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_HALF2: begin
                    // end of integration, hand over to the adc
                    if (cnt_q == 32'h0) begin
                        integ_active_q <= 1'b0;
                        state_q <= ST_CONV;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_CONV: begin
                    // combine this pulse, then the next pulse or the end
                    if (adc_valid) begin
                        acc_q <= acc_d;
                        pos_q <= pos_q + 2'h1;
                        pulse_idx_q <= pulse_idx_q + 8'h01;
                        if (pulse_idx_q == total_q - 8'h01) begin
                            state_q <= ST_DONE;
                        end else begin
                            cnt_q <= start_cyc;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_DONE: begin
                    // single write after the last pulse
                    sample_data_q <= result_d;
                    sample_valid_q <= 1'b1;
                    busy_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // input connection control
    // ------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sensor_connect_q <= 1'b0;
            sensor_precon_q <= 1'b0;
        end else if (clk_en) begin
            case (input_connect_mode)
                `CONN_CONTINUOUS: begin
                    sensor_connect_q <= pre_sync;
                    sensor_precon_q <= ~pre_sync;
                end
                `CONN_FLOAT: begin
                    sensor_connect_q <= win_sync;
                    sensor_precon_q <= 1'b0;
                end
                `CONN_PRECON: begin
                    sensor_connect_q <= win_sync;
                    sensor_precon_q <= ~win_sync;
                end
                default: begin
                    sensor_connect_q <= pre_sync;
                    sensor_precon_q <= ~pre_sync;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // pattern readback for selected slot
    // ------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pattern_rd_q <= `PATTERN_RESET;
        end else if (clk_en) begin
            pattern_rd_q <= 16'h0000;
            for (j = 0; j < NUM_SLOTS; j = j + 1) begin
                if (slot_sel == j[3:0]) begin
                    pattern_rd_q <= pattern_flat[16*j +: 16];
                end
            end
        end
    end
endmodule // pulse_chop_accumulator

/* File: bench/chop_properties.sv */
// port assertions for the pulse chop accumulator
`timescale 1ns/100ps
module chop_props #(
    parameter ACC_W = 24 // result width
) (
    input wire ref_clk, // clock
    input wire rst, // reset
    input wire clk_en, // run
    input wire sample_start, // start
    input wire [7:0] pulse_repeat_count, // pulses
    input wire [1:0] input_connect_mode, // mode
    input wire midscale_bias_add, // bias
    input wire pulse_window, // window pin
    input wire precon_done, // precondition over
    input wire integ_active_q, // integrating
    input wire integ_phase_q, // phase
    input wire sensor_connect_q, // connect
    input wire sensor_precon_q, // precondition tie
    input wire [ACC_W-1:0] sample_data_q, // result
    input wire sample_valid_q, // result strobe
    input wire busy_q // busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ---------------------------------------------
    // sample sequencing
    // ---------------------------------------------
    property p_valid_one; sample_valid_q |=> !sample_valid_q; endproperty
    a_valid_one: assert property (p_valid_one) else $error("valid strobe too long");
    property p_data_hold; !sample_valid_q |-> $stable(sample_data_q); endproperty
    a_data_hold: assert property (p_data_hold) else $error("result moved without strobe");
    property p_start; sample_start && clk_en && !busy_q && !sample_valid_q && pulse_repeat_count != 8'h00 |=> busy_q;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_zero; sample_start && !busy_q && !sample_valid_q && pulse_repeat_count == 8'h00 |=> !busy_q; endproperty
    a_zero: assert property (p_zero) else $error("empty sample started");
    property p_idle; !busy_q |-> !integ_active_q; endproperty
    a_idle: assert property (p_idle) else $error("integrating while idle");
    property p_integ_len; $rose(integ_active_q) |-> integ_active_q[*8] ##1 !integ_active_q; endproperty
    a_integ_len: assert property (p_integ_len) else $error("integration length wrong");
    property p_phase_half; $rose(integ_active_q) |-> ##4 integ_phase_q != $past(integ_phase_q, 4); endproperty
    a_phase_half: assert property (p_phase_half) else $error("phase not swapped at half");
    // ---------------------------------------------
    // input connection modes
    // ---------------------------------------------
    property p_mode0; input_connect_mode == 2'h0 && $past(input_connect_mode, 3) == 2'h0 && $past(precon_done, 3)
        |-> sensor_connect_q && !sensor_precon_q; endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 not connected");
    property p_mode1; input_connect_mode == 2'h1 && $past(input_connect_mode, 3) == 2'h1
        |-> sensor_connect_q == $past(pulse_window, 3) && !sensor_precon_q; endproperty
    a_mode1: assert property (p_mode1) else $error("mode 1 connect wrong");
    property p_mode2; input_connect_mode == 2'h2 && $past(input_connect_mode, 3) == 2'h2
        |-> sensor_connect_q == $past(pulse_window, 3) && sensor_precon_q == !$past(pulse_window, 3); endproperty
    a_mode2: assert property (p_mode2) else $error("mode 2 connect wrong");
    c_bias: cover property (sample_valid_q && midscale_bias_add);
    c_negative: cover property (sample_valid_q && sample_data_q[ACC_W-1]);
    c_inverted: cover property ($rose(integ_active_q) && !integ_phase_q);
endmodule // chop_props
bind pulse_chop_accumulator chop_props #(.ACC_W(ACC_W)) props (.ref_clk, .rst, .clk_en, .sample_start,
    .pulse_repeat_count, .input_connect_mode, .midscale_bias_add, .pulse_window, .precon_done, .integ_active_q,
    .integ_phase_q, .sensor_connect_q, .sensor_precon_q, .sample_data_q, .sample_valid_q, .busy_q);

/* File: bench/sensor_model.sv */
// sensor and receive path model, one result per integration
`timescale 1ns/100ps
module sensor_model (
    input wire ref_clk, // clock
    input wire rst, // reset
    input wire busy_q, // sample running
    input wire integ_active_q, // integrating
    output reg pulse_window, // modulation pulse
    output reg precon_done, // precondition over
    output reg adc_valid, // result strobe
    output reg [13:0] adc_data // result, 100 + 10 per pulse
);
    reg [1:0] st_q;
    reg [1:0] dly_q;
    reg [7:0] k_q;
    // window until integration ends, result four cycles on, then a gap
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= 2'h0;
            dly_q <= 2'h0;
            k_q <= 8'h00;
            pulse_window <= 1'h0;
            precon_done <= 1'h0;
            adc_valid <= 1'h0;
            adc_data <= 14'h2AAA;
        end else begin
            precon_done <= 1'h1;
            adc_valid <= 1'h0;
            adc_data <= ~adc_data; // no stale value outside the strobe
            dly_q <= dly_q + 2'h1;
            if (!busy_q) begin
                st_q <= 2'h0;
                k_q <= 8'h00;
                pulse_window <= 1'h0;
            end else if (st_q == 2'h0) begin
                pulse_window <= 1'h1;
                st_q <= integ_active_q ? 2'h1 : 2'h0;
            end else if (st_q == 2'h1 && !integ_active_q) begin
                pulse_window <= 1'h0;
                dly_q <= 2'h0;
                st_q <= 2'h2;
            end else if (st_q != 2'h1 && dly_q == 2'h3) begin
                adc_valid <= st_q == 2'h2;
                adc_data <= 14'h0064 + 14'h000A * k_q; // trims held at zero, no offset added
                k_q <= k_q + {7'h00, st_q == 2'h2};
                st_q <= st_q == 2'h2 ? 2'h3 : 2'h0;
            end
        end
    end
endmodule // sensor_model

/* File: bench/testbench.sv */
// self-checking bench for the pulse chop accumulator
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [7:0] cnt;
        logic [11:0] addr;
        logic [3:0] slot;
        logic [7:0] pat;
        logic bias;
        logic [1:0] mode;
        logic [23:0] exp;
    } row_t;
    reg ref_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, sample_start = 0, midscale_bias_add = 0;
    reg [11:0] reg_addr = 0;
    reg [15:0] reg_wdata = 0;
    reg [3:0] slot_sel = 0;
    reg [12:0] integration_start_time = 13'h0001;
    reg [7:0] pulse_repeat_count = 0;
    reg [1:0] input_connect_mode = 0;
    wire pulse_window, precon_done, adc_valid, integ_active_q, integ_phase_q, sensor_connect_q, sensor_precon_q;
    wire sample_valid_q, busy_q;
    wire [13:0] adc_data;
    wire [23:0] sample_data_q;
    wire [15:0] pattern_rd_q;
    int err_total = 0, tests_run = 0, wcnt = 0, last_lat = 0, lat_f, i, k;
    reg act_d = 0, win_d = 0;
    reg ph_q[$];
    row_t rows[5];
    always #2.5 ref_clk = ~ref_clk;
    pulse_chop_accumulator dut (.ref_clk, .rst, .clk_en, .reg_wr, .reg_addr, .reg_wdata, .slot_sel, .sample_start,
        .integration_start_time, .pulse_repeat_count, .input_connect_mode, .midscale_bias_add, .adc_valid,
        .adc_data, .pulse_window, .precon_done, .integ_active_q, .integ_phase_q, .sensor_connect_q,
        .sensor_precon_q, .sample_data_q, .sample_valid_q, .busy_q, .pattern_rd_q);
    sensor_model model (.ref_clk, .rst, .busy_q, .integ_active_q, .pulse_window, .precon_done, .adc_valid,
        .adc_data);
    // first-pulse start latency and the opening phase of every pulse
    always @(posedge ref_clk) begin
        act_d <= integ_active_q;
        win_d <= pulse_window;
        wcnt = (pulse_window && !win_d) ? 0 : wcnt + 1;
        if (integ_active_q && !act_d) begin
            if (ph_q.size() == 0)
                last_lat = wcnt;
            ph_q.push_back(integ_phase_q);
        end
    end
    task note(input logic ok, input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (!ok) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task chk_data(input logic [23:0] g, input logic [23:0] e);
        note(g === e, {8'h00, g}, {8'h00, e});
    endtask
    task chk_reg(input logic [15:0] g, input logic [15:0] e);
        note(g === e, {16'h0000, g}, {16'h0000, e});
    endtask
    task chk_bit(input logic g, input logic e);
        note(g === e, {31'h0, g}, {31'h0, e});
    endtask
    task chk_num(input logic [31:0] g, input logic [31:0] e);
        note(g === e, g, e);
    endtask
    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    // one sample; the pause variant pulses start again while busy, then freezes 30 cycles
    task run(input logic [7:0] c, input logic [12:0] t, input bit pause);
        ph_q.delete();
        @(posedge ref_clk);
        pulse_repeat_count <= c;
        integration_start_time <= t;
        sample_start <= 1'h1;
        @(posedge ref_clk);
        sample_start <= 1'h0;
        if (pause) begin
            repeat (50) @(posedge ref_clk);
            sample_start <= 1'h1;
            @(posedge ref_clk);
            sample_start <= 1'h0;
            clk_en <= 1'h0;
            repeat (30) @(posedge ref_clk);
            clk_en <= 1'h1;
        end
        k = 0;
        while (sample_valid_q !== 1'h1 && k < 5000) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk_bit(k < 5000, 1'h1);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial begin
        rows[0] = {8'h04, 12'h10D, 4'h0, 8'h00, 1'h0, 2'h0, 24'h0001CC};
        rows[1] = {8'h04, 12'h12D, 4'h1, 8'hAA, 1'h0, 2'h1, 24'hFFFFEC};
        rows[2] = {8'h06, 12'h14D, 4'h2, 8'hA0, 1'h0, 2'h2, 24'hFFFFE2};
        rows[3] = {8'h08, 12'h26D, 4'hB, 8'h5F, 1'h1, 2'h0, 24'h000828};
        rows[4] = {8'h01, 12'h16D, 4'h3, 8'h10, 1'h1, 2'h2, 24'h00079C};
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        #1;
        chk_data(sample_data_q, 24'h000000);
        chk_reg(pattern_rd_q, 16'h0000);
        for (i = 0; i < 5; i++) begin
            wr(rows[i].addr, {8'hC3, rows[i].pat});
            slot_sel <= rows[i].slot;
            midscale_bias_add <= rows[i].bias;
            input_connect_mode <= rows[i].mode;
            repeat (4) @(posedge ref_clk);
            #1;
            chk_reg(pattern_rd_q, {8'hC3, rows[i].pat});
            run(rows[i].cnt, 13'h0001, 1'b0);
            chk_data(sample_data_q, rows[i].exp);
            for (k = 0; k < rows[i].cnt; k++)
                chk_bit(ph_q[k], !rows[i].pat[k % 4]);
        end
        lat_f = last_lat;
        run(8'h02, 13'h003F, 1'b0);
        chk_num(last_lat - lat_f, 410);
        chk_data(sample_data_q, 24'h00080A);
        run(8'h02, 13'h0020, 1'b1);
        chk_num(last_lat - lat_f, 223);
        chk_data(sample_data_q, 24'h00080A);
        wr(12'h16E, 16'hFFFF);
        repeat (4) @(posedge ref_clk);
        #1;
        chk_reg(pattern_rd_q, 16'hC310);
        @(posedge ref_clk);
        pulse_repeat_count <= 8'h00;
        sample_start <= 1'h1;
        @(posedge ref_clk);
        sample_start <= 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk_bit(busy_q, 1'h0);
        tally_and_finish;
    end
    // watchdog, far beyond the few thousand cycles the run needs
    initial begin
        #250000;
        err_total++;
        tally_and_finish;
    end
endmodule // testbench
